// ### rtl/scsi_err_defs.svh
/*
  Constants of the target bus error handler: sense layout and values,
  identify field positions, opcodes and blocking-condition ranks.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef SCSI_ERR_DEFS_SVH
`define SCSI_ERR_DEFS_SVH

// Sense word: key [19:16], additional code [15:8], qualifier [7:0]
`define SNS_W 20
`define SNS_NONE 20'h00000
`define SNS_PARITY 20'hB4700
`define SNS_IDE 20'hB4800
`define SNS_MREJ 20'hB4300
`define SNS_NOLUN 20'h52500

// Connection and storage sizes
`define INIT_W 4
`define MEM_DEPTH 16
`define LUN_W 6
`define NUM_LUN 6'h01

// Identify message fields
`define ID_DISC_BIT 6
`define ID_LUN_MSB 5

// Opcodes that bypass the invalid-unit check condition
`define OP_INQUIRY 8'h12
`define OP_REQSENSE 8'h03

// Inquiry peripheral type
`define PDT_W 5
`define PDT_NOLUN 5'h1F
`define PDT_DISK 5'h00

// Blocking condition ranks, 1 is highest, 0 means none
`define BLK_N 8
`define RANK_W 4
`define RANK_NONE 4'h0
`define RANK_BUSY 4'h3
`define RANK_RESV 4'h7

`endif

// ### rtl/scsi_err_pkg.sv
/*
  Types of the target bus error handler: phases, messages, events,
  actions and recovery states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package scsi_err_pkg;

  typedef enum logic [2:0] {
    P_CMD, P_DIN, P_DOUT, P_STAT, P_MIN, P_MOUT, P_OTHER
  } phase_type;

  typedef enum logic [2:0] {
    M_NONE, M_DISC, M_TC, M_IDENT, M_LCC, M_MREJ, M_RESTORE, M_SDP
  } msg_type;

  typedef enum logic [2:0] {
    EV_CAT, EV_PAR_MOUT, EV_PAR_MIN, EV_PAR_CMD, EV_PAR_DOUT, EV_IDE, EV_MREJ
  } ev_type;

  typedef enum logic [3:0] {
    ACT_NONE, ACT_BUSFREE, ACT_CHECK, ACT_RETRY_MSG, ACT_RETRY_CMD,
    ACT_RETRY_STAT, ACT_REJECT, ACT_STAY, ACT_EXEC, ACT_INQ_NOLUN,
    ACT_SENSE, ACT_BUSY, ACT_RESV
  } act_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RETRY = 2'b10
  } state_type;

endpackage

// ### rtl/sense_mem_if.sv
/*
  Port between the error handler and its sense store.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scsi_err_defs.svh"

interface sense_mem_if;
  logic we;
  logic re;
  logic [`INIT_W-1:0] addr;
  logic [`SNS_W-1:0] wdata;
  logic [`SNS_W-1:0] rdata;

  modport owner (output we, output re, output addr, output wdata, input rdata);
  modport mem (input we, input re, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

// ### rtl/sense_mem.sv
/*
  Sense store, one word per initiator, registered read, read-first.
  Assumes one write and one read address per cycle from the owner.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scsi_err_defs.svh"

module sense_mem (
  input wire logic clk,
  input wire logic rstn,
  sense_mem_if.mem port
);
  logic [`SNS_W-1:0] store_ff [`MEM_DEPTH];
  logic [`SNS_W-1:0] rdata_ff;

  // Reset leaves no stale sense pending for anyone
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `MEM_DEPTH; i++) begin
        store_ff[i] <= `SNS_NONE;
      end
    end else if (port.we) begin
      store_ff[port.addr] <= port.wdata;
    end
  end

  // Read-first, so a clear in the same cycle still returns the old word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= `SNS_NONE;
    end else if (port.re) begin
      rdata_ff <= store_ff[port.addr];
    end
  end

  assign port.rdata = rdata_ff;
endmodule

`default_nettype wire

// ### rtl/scsi_target_err.sv
/*
  Target-side bus error handler: turns parity, catastrophic, reject and
  command events into bus actions and keeps sense per initiator.
  Assumes a phase engine on the same clock that gives one event at a
  time as a one-cycle pulse and carries out the action it is given.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scsi_err_defs.svh"
// Notes on behaviour
// - Catastrophic errors go to bus free at once, whatever ATN shows.
// - After such a bus free, never reselect to finish that operation.
// - Unit known: abort its command and store sense naming the cause.
// - Unit unknown: leave every sense word and command untouched.
// - Message out parity: optional retry, then check condition, parity sense.
// - Message in parity: optional retry, then abort, bus free, parity sense.
// - Command parity: optional restore pointers and retry, then check condition.
// - Data out parity: no retry, check condition with parity sense.
// - Initiator detected error is valid only after command, data or status.
// - Valid initiator error: retry command or status, else check condition.
// - Rejected disconnect: stay connected.
// - Rejected task complete: no error, go to bus free.
// - Rejected identify or linked complete: abort, unlink, bus free, reject sense.
// - Rejected own reject: abort, status with check condition, reject sense.
// - Rejected restore pointers: check condition, sense of the original error.
// - Rejected save data pointer: stay on the bus, no error.
// - Reject with no message sent: abort, bus free, reject sense.
// - Report only the highest blocking condition, and none on a bus error.
// - Build sense on check condition with valid unit; next command clears it.
// - Inquiry to an unsupported unit returns peripheral type not supported.
// - Other commands to bad unit: check condition; request sense: unit unsupported.
// - Repeated identify must keep the unit; a changed unit means bus free.
// - Identify bit 6 grants disconnect, bits 5-0 give the unit.

module scsi_target_err (
  input wire logic clk,
  input wire logic rstn,
  input wire logic retryEnable,
  input wire logic [`INIT_W-1:0] initiatorId,
  input wire logic selectStart,
  input wire logic evValid,
  input wire scsi_err_pkg::ev_type evKind,
  input wire scsi_err_pkg::phase_type lastPhase,
  input wire scsi_err_pkg::msg_type lastMsgOut,
  input wire logic identifyValid,
  input wire logic [7:0] identifyByte,
  input wire logic retryDone,
  input wire logic cmdValid,
  input wire logic [7:0] cmdOpcode,
  input wire logic [`BLK_N-1:0] blockVec,
  input wire logic busError,
  input wire logic [`SNS_W-1:0] causeSense,
  output logic actValid,
  output logic [3:0] actCode,
  output logic abortCmd,
  output logic breakLink,
  output logic lunKnown,
  output logic [`LUN_W-1:0] lunId,
  output logic discAllowed,
  output logic reselectInhibit,
  output logic senseValid,
  output logic [`SNS_W-1:0] senseData,
  output logic [`PDT_W-1:0] inquiryPdt
);
  sense_mem_if mif ();

  scsi_err_pkg::state_type state_ff, nxt_state;
  scsi_err_pkg::act_type actCode_ff, nxt_act;
  logic [`SNS_W-1:0] origSense_ff, nxt_orig;
  logic lunKnown_ff, discAllowed_ff, abort_ff, break_ff, inhibit_ff;
  logic senseValid_ff, nolun_ff, nxt_abort, nxt_break, nxt_senseValid;
  logic nxt_nolun, discClr, doCat, lunChange, lunInRange, unitOk, invLun;
  logic canRetry, isInq, isReqSense;
  logic [`LUN_W-1:0] lun_ff;
  logic [`PDT_W-1:0] pdt_ff, nxt_pdt;
  logic [`RANK_W-1:0] rank;

  // Phases after which the initiator may flag its own error
  function automatic logic isXfer(input scsi_err_pkg::phase_type ph);
    return ph == scsi_err_pkg::P_CMD || ph == scsi_err_pkg::P_DIN ||
           ph == scsi_err_pkg::P_DOUT || ph == scsi_err_pkg::P_STAT;
  endfunction

  // Lowest set bit wins; bit 0 is rank 2 since rank 1 is the unit check
  function automatic logic [`RANK_W-1:0] blockRank(input logic [`BLK_N-1:0] vec);
    logic [`RANK_W-1:0] r;
    r = `RANK_NONE;
    for (int i = `BLK_N - 1; i >= 0; i--) begin
      if (vec[i]) begin
        r = `RANK_W'(i + 2);
      end
    end
    return r;
  endfunction

  sense_mem u_mem (
    .clk(clk),
    .rstn(rstn),
    .port(mif)
  );

  // Nexus decode shared by every path
  assign lunChange = identifyValid && lunKnown_ff &&
                     identifyByte[`ID_LUN_MSB:0] != lun_ff;
  assign doCat = (evValid && evKind == scsi_err_pkg::EV_CAT) || lunChange;
  assign lunInRange = lun_ff < `NUM_LUN;
  assign unitOk = lunKnown_ff && lunInRange;
  assign invLun = lunKnown_ff && !lunInRange;
  assign canRetry = retryEnable && state_ff == scsi_err_pkg::ST_IDLE;
  assign isInq = cmdOpcode == `OP_INQUIRY;
  assign isReqSense = cmdOpcode == `OP_REQSENSE;
  assign rank = blockRank(blockVec);

  // Event decode: one action per cycle, event first, then command
  always_comb begin
    nxt_act = scsi_err_pkg::ACT_NONE;
    nxt_state = retryDone ? scsi_err_pkg::ST_IDLE : state_ff;
    nxt_orig = origSense_ff;
    nxt_abort = 1'b0;
    nxt_break = 1'b0;
    nxt_senseValid = 1'b0;
    nxt_nolun = nolun_ff;
    nxt_pdt = pdt_ff;
    discClr = 1'b0;
    mif.we = 1'b0;
    mif.re = 1'b0;
    mif.addr = initiatorId;
    mif.wdata = `SNS_NONE;
    if (doCat) begin
      // Bus free even with ATN pending; sense only for a known unit
      nxt_act = scsi_err_pkg::ACT_BUSFREE;
      nxt_state = scsi_err_pkg::ST_IDLE;
      nxt_abort = unitOk;
      mif.we = unitOk;
      mif.wdata = causeSense;
    end else if (evValid) begin
      case (evKind)
        scsi_err_pkg::EV_PAR_MOUT, scsi_err_pkg::EV_PAR_CMD: begin
          if (canRetry) begin
            nxt_act = evKind == scsi_err_pkg::EV_PAR_CMD ?
                      scsi_err_pkg::ACT_RETRY_CMD : scsi_err_pkg::ACT_RETRY_MSG;
            nxt_state = scsi_err_pkg::ST_RETRY;
            nxt_orig = `SNS_PARITY;
          end else begin
            nxt_act = scsi_err_pkg::ACT_CHECK;
            nxt_state = scsi_err_pkg::ST_IDLE;
            nxt_abort = 1'b1;
            mif.we = unitOk;
            mif.wdata = `SNS_PARITY;
          end
        end
        scsi_err_pkg::EV_PAR_MIN: begin
          if (canRetry) begin
            nxt_act = scsi_err_pkg::ACT_RETRY_MSG;
            nxt_state = scsi_err_pkg::ST_RETRY;
            nxt_orig = `SNS_PARITY;
          end else begin
            nxt_act = scsi_err_pkg::ACT_BUSFREE;
            nxt_state = scsi_err_pkg::ST_IDLE;
            nxt_abort = 1'b1;
            mif.we = unitOk;
            mif.wdata = `SNS_PARITY;
          end
        end
        scsi_err_pkg::EV_PAR_DOUT: begin
          // Data already consumed cannot be replayed, so no retry here
          nxt_act = scsi_err_pkg::ACT_CHECK;
          nxt_state = scsi_err_pkg::ST_IDLE;
          nxt_abort = 1'b1;
          mif.we = unitOk;
          mif.wdata = `SNS_PARITY;
        end
        scsi_err_pkg::EV_IDE: begin
          if (!isXfer(lastPhase)) begin
            nxt_act = scsi_err_pkg::ACT_REJECT;
          end else if (canRetry && (lastPhase == scsi_err_pkg::P_CMD ||
                                    lastPhase == scsi_err_pkg::P_STAT)) begin
            nxt_act = lastPhase == scsi_err_pkg::P_CMD ?
                      scsi_err_pkg::ACT_RETRY_CMD : scsi_err_pkg::ACT_RETRY_STAT;
            nxt_state = scsi_err_pkg::ST_RETRY;
            nxt_orig = `SNS_IDE;
          end else begin
            nxt_act = scsi_err_pkg::ACT_CHECK;
            nxt_state = scsi_err_pkg::ST_IDLE;
            nxt_abort = 1'b1;
            mif.we = unitOk;
            mif.wdata = `SNS_IDE;
          end
        end
        scsi_err_pkg::EV_MREJ: begin
          case (lastMsgOut)
            scsi_err_pkg::M_DISC: begin
              nxt_act = scsi_err_pkg::ACT_STAY;
            end
            scsi_err_pkg::M_TC: begin
              nxt_act = scsi_err_pkg::ACT_BUSFREE;
            end
            scsi_err_pkg::M_IDENT, scsi_err_pkg::M_LCC: begin
              nxt_act = scsi_err_pkg::ACT_BUSFREE;
              nxt_state = scsi_err_pkg::ST_IDLE;
              nxt_abort = 1'b1;
              nxt_break = 1'b1;
              mif.we = unitOk;
              mif.wdata = `SNS_MREJ;
            end
            scsi_err_pkg::M_MREJ: begin
              nxt_act = scsi_err_pkg::ACT_CHECK;
              nxt_state = scsi_err_pkg::ST_IDLE;
              nxt_abort = 1'b1;
              mif.we = unitOk;
              mif.wdata = `SNS_MREJ;
            end
            scsi_err_pkg::M_RESTORE: begin
              // Recovery failed; report what started it, not the reject
              nxt_act = scsi_err_pkg::ACT_CHECK;
              nxt_state = scsi_err_pkg::ST_IDLE;
              nxt_abort = 1'b1;
              mif.we = unitOk;
              mif.wdata = origSense_ff;
            end
            scsi_err_pkg::M_SDP: begin
              nxt_act = scsi_err_pkg::ACT_STAY;
              discClr = 1'b1;
            end
            default: begin
              nxt_act = scsi_err_pkg::ACT_BUSFREE;
              nxt_state = scsi_err_pkg::ST_IDLE;
              nxt_abort = 1'b1;
              mif.we = unitOk;
              mif.wdata = `SNS_MREJ;
            end
          endcase
        end
        default: begin
          nxt_act = scsi_err_pkg::ACT_NONE;
        end
      endcase
    end else if (cmdValid && !busError) begin
      nxt_pdt = `PDT_DISK;
      nxt_nolun = 1'b0;
      if (invLun) begin
        if (isInq) begin
          nxt_act = scsi_err_pkg::ACT_INQ_NOLUN;
          nxt_pdt = `PDT_NOLUN;
        end else if (isReqSense) begin
          nxt_act = scsi_err_pkg::ACT_SENSE;
          nxt_senseValid = 1'b1;
          nxt_nolun = 1'b1;
        end else begin
          nxt_act = scsi_err_pkg::ACT_CHECK;
        end
      end else begin
        // A new command to a known unit clears, unless its rank gives check condition; read-first still hands old sense out
        mif.we = unitOk;
        mif.re = isReqSense;
        nxt_senseValid = isReqSense;
        if (rank == `RANK_NONE) begin
          nxt_act = isReqSense ? scsi_err_pkg::ACT_SENSE : scsi_err_pkg::ACT_EXEC;
        end else if (rank == `RANK_BUSY) begin
          nxt_act = scsi_err_pkg::ACT_BUSY;
        end else if (rank == `RANK_RESV) begin
          nxt_act = scsi_err_pkg::ACT_RESV;
        end else begin
          nxt_act = scsi_err_pkg::ACT_CHECK;
          mif.wdata = causeSense;
        end
      end
    end
  end

  // Recovery state and the sense to report if recovery is rejected
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= scsi_err_pkg::ST_IDLE;
      origSense_ff <= `SNS_NONE;
    end else begin
      state_ff <= nxt_state;
      origSense_ff <= nxt_orig;
    end
  end

  // Nexus: unit and disconnect privilege from identify
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lunKnown_ff <= 1'b0;
      lun_ff <= '0;
      discAllowed_ff <= 1'b0;
    end else if (selectStart || doCat) begin
      lunKnown_ff <= 1'b0;
      discAllowed_ff <= 1'b0;
    end else if (identifyValid) begin
      lunKnown_ff <= 1'b1;
      lun_ff <= identifyByte[`ID_LUN_MSB:0];
      discAllowed_ff <= identifyByte[`ID_DISC_BIT];
    end else if (discClr) begin
      discAllowed_ff <= 1'b0;
    end
  end

  // Reconnect block stays until a fresh command starts a new operation
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      inhibit_ff <= 1'b0;
    end else if (doCat) begin
      inhibit_ff <= 1'b1;
    end else if (cmdValid) begin
      inhibit_ff <= 1'b0;
    end
  end

  // Action outputs, one-cycle pulses; the no-unit flag and peripheral type hold their value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      actCode_ff <= scsi_err_pkg::ACT_NONE;
      abort_ff <= 1'b0;
      break_ff <= 1'b0;
      senseValid_ff <= 1'b0;
      nolun_ff <= 1'b0;
      pdt_ff <= `PDT_DISK;
    end else begin
      actCode_ff <= nxt_act;
      abort_ff <= nxt_abort;
      break_ff <= nxt_break;
      senseValid_ff <= nxt_senseValid;
      nolun_ff <= nxt_nolun;
      pdt_ff <= nxt_pdt;
    end
  end

  assign actValid = actCode_ff != scsi_err_pkg::ACT_NONE;
  assign actCode = actCode_ff;
  assign abortCmd = abort_ff;
  assign breakLink = break_ff;
  assign lunKnown = lunKnown_ff;
  assign lunId = lun_ff;
  assign discAllowed = discAllowed_ff;
  assign reselectInhibit = inhibit_ff;
  assign senseValid = senseValid_ff;
  assign senseData = nolun_ff ? `SNS_NOLUN : mif.rdata;
  assign inquiryPdt = pdt_ff;

  // Checks on the decode against the pulses it produces
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_cat_busfree: assert property (
    doCat |=> actCode_ff == scsi_err_pkg::ACT_BUSFREE
  ) else $error("catastrophic error did not free the bus");

  chk_no_reselect: assert property (
    (doCat || (inhibit_ff && !cmdValid)) |=> inhibit_ff
  ) else $error("reselect not inhibited after bus free");

  chk_abort_known: assert property (
    (doCat && unitOk) |-> mif.we && mif.wdata == causeSense ##1 abort_ff
  ) else $error("known unit not aborted with sense");

  chk_unknown_untouched: assert property (
    (doCat && !unitOk) |-> !mif.we ##1 !abort_ff
  ) else $error("unknown unit state was touched");

  chk_dout_noretry: assert property (
    (evValid && !doCat && evKind == scsi_err_pkg::EV_PAR_DOUT) |=>
      actCode_ff == scsi_err_pkg::ACT_CHECK && abort_ff
  ) else $error("data out parity not ended with check condition");

  chk_ide_reject: assert property (
    (evValid && !doCat && evKind == scsi_err_pkg::EV_IDE && !isXfer(lastPhase)) |=>
      actCode_ff == scsi_err_pkg::ACT_REJECT
  ) else $error("misplaced initiator error not rejected");

  chk_single_retry: assert property (
    (state_ff == scsi_err_pkg::ST_RETRY && !retryDone) |=>
      actCode_ff != scsi_err_pkg::ACT_RETRY_MSG &&
      actCode_ff != scsi_err_pkg::ACT_RETRY_CMD &&
      actCode_ff != scsi_err_pkg::ACT_RETRY_STAT
  ) else $error("second retry attempted");

  chk_disc_stay: assert property (
    (evValid && !doCat && evKind == scsi_err_pkg::EV_MREJ &&
     lastMsgOut == scsi_err_pkg::M_DISC) |=>
      actCode_ff == scsi_err_pkg::ACT_STAY && !abort_ff
  ) else $error("rejected disconnect released the bus");

  chk_restore_sense: assert property (
    (evValid && !doCat && evKind == scsi_err_pkg::EV_MREJ &&
     lastMsgOut == scsi_err_pkg::M_RESTORE && unitOk) |->
      mif.wdata == origSense_ff ##1 actCode_ff == scsi_err_pkg::ACT_CHECK
  ) else $error("restore reject lost original sense");

  chk_lun_change: assert property (
    lunChange |=> actCode_ff == scsi_err_pkg::ACT_BUSFREE && !lunKnown_ff
  ) else $error("changed unit did not free the bus");

  cov_retry_ok: cover property (
    state_ff == scsi_err_pkg::ST_RETRY ##1 state_ff == scsi_err_pkg::ST_IDLE
  );
  cov_restore_rej: cover property (
    evValid && evKind == scsi_err_pkg::EV_MREJ && lastMsgOut == scsi_err_pkg::M_RESTORE
  );
  cov_nolun_sense: cover property (
    senseValid_ff && nolun_ff
  );
endmodule

`default_nettype wire

// ### tb/init_model.sv
/* Initiator stand-in: drives every strobe and level of the error handler except clock and reset.
   Assumes the bench calls its tasks; all changes land on falling edges. */
`timescale 1ns/1ps
`default_nettype none
`include "scsi_err_defs.svh"
module init_model (
  input wire logic clk,
  output logic retryEnable,
  output logic [`INIT_W-1:0] initiatorId,
  output logic selectStart,
  output logic evValid,
  output var scsi_err_pkg::ev_type evKind,
  output var scsi_err_pkg::phase_type lastPhase,
  output var scsi_err_pkg::msg_type lastMsgOut,
  output logic identifyValid,
  output logic [7:0] identifyByte,
  output logic retryDone,
  output logic cmdValid,
  output logic [7:0] cmdOpcode,
  output logic [`BLK_N-1:0] blockVec,
  output logic busError,
  output logic [`SNS_W-1:0] causeSense
);
  // Quiet bus at time zero
  initial begin
    {retryEnable, initiatorId, selectStart, evValid, identifyValid, retryDone} = '0;
    {cmdValid, busError, blockVec, identifyByte, cmdOpcode} = '0;
    causeSense = 20'h44400;
    evKind = scsi_err_pkg::EV_CAT;
    lastPhase = scsi_err_pkg::P_OTHER;
    lastMsgOut = scsi_err_pkg::M_NONE;
  end
  // Each strobe is high across exactly one rising edge
  task automatic select();
    @(negedge clk);
    selectStart = 1'h1;
    @(negedge clk);
    selectStart = 1'h0;
  endtask
  // Top bit marks the message, next grants disconnect, low bits the unit
  task automatic ident(input logic disc, input logic [5:0] unit);
    @(negedge clk);
    identifyByte = {1'h1, disc, unit};
    identifyValid = 1'h1;
    @(negedge clk);
    identifyValid = 1'h0;
    identifyByte = ~identifyByte; // Stale byte must not look valid
  endtask
  task automatic sendEv(input logic [2:0] k, input logic [2:0] p, input logic [2:0] m);
    @(negedge clk);
    evKind = scsi_err_pkg::ev_type'(k);
    lastPhase = scsi_err_pkg::phase_type'(p);
    lastMsgOut = scsi_err_pkg::msg_type'(m);
    evValid = 1'h1;
    @(negedge clk);
    evValid = 1'h0;
  endtask
  task automatic cmd(input logic [7:0] op, input logic be, input logic [7:0] bv);
    @(negedge clk);
    {cmdOpcode, busError, blockVec} = {op, be, bv};
    cmdValid = 1'h1;
    @(negedge clk);
    {cmdValid, busError, blockVec} = '0;
    cmdOpcode = ~cmdOpcode;
  endtask
  task automatic done();
    @(negedge clk);
    retryDone = 1'h1;
    @(negedge clk);
    retryDone = 1'h0;
  endtask
endmodule
`default_nettype wire

// ### tb/scsi_target_error_handler_bench.sv
/* Self-checking bench of the target error handler: a table of events
   then hand-written cases. Assumes the initiator stand-in drives inputs. */
`timescale 1ns/1ps
`default_nettype none
`include "scsi_err_defs.svh"
module scsi_target_error_handler_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic retryEnable, selectStart, evValid, identifyValid, retryDone, cmdValid, busError;
  logic [`INIT_W-1:0] initiatorId;
  scsi_err_pkg::ev_type evKind;
  scsi_err_pkg::phase_type lastPhase;
  scsi_err_pkg::msg_type lastMsgOut;
  logic [7:0] identifyByte, cmdOpcode, blockVec;
  logic [`SNS_W-1:0] causeSense, senseData;
  logic actValid, abortCmd, breakLink, lunKnown, discAllowed, reselectInhibit, senseValid;
  logic [3:0] actCode;
  logic [5:0] lunId;
  logic [4:0] inquiryPdt;
  int fails = 0;
  int comparisons = 0;
  // Columns: event, last phase, last message, action, abort, sense after
  typedef struct packed {
    logic [2:0] k;
    logic [2:0] p;
    logic [2:0] m;
    logic [3:0] a;
    logic ab;
    logic [`SNS_W-1:0] s;
  } row_type;
  row_type rows [15] = '{
    '{3'h4, 3'h2, 3'h0, 4'h2, 1'h1, `SNS_PARITY},
    '{3'h1, 3'h5, 3'h0, 4'h2, 1'h1, `SNS_PARITY},
    '{3'h2, 3'h4, 3'h0, 4'h1, 1'h1, `SNS_PARITY},
    '{3'h3, 3'h0, 3'h0, 4'h2, 1'h1, `SNS_PARITY},
    '{3'h5, 3'h1, 3'h0, 4'h2, 1'h1, `SNS_IDE},
    '{3'h5, 3'h2, 3'h0, 4'h2, 1'h1, `SNS_IDE},
    '{3'h5, 3'h4, 3'h0, 4'h6, 1'h0, `SNS_NONE},
    '{3'h6, 3'h6, 3'h1, 4'h7, 1'h0, `SNS_NONE},
    '{3'h6, 3'h6, 3'h2, 4'h1, 1'h0, `SNS_NONE},
    '{3'h6, 3'h6, 3'h3, 4'h1, 1'h1, `SNS_MREJ},
    '{3'h6, 3'h6, 3'h4, 4'h1, 1'h1, `SNS_MREJ},
    '{3'h6, 3'h6, 3'h5, 4'h2, 1'h1, `SNS_MREJ},
    '{3'h6, 3'h6, 3'h7, 4'h7, 1'h0, `SNS_NONE},
    '{3'h6, 3'h6, 3'h0, 4'h1, 1'h1, `SNS_MREJ},
    '{3'h0, 3'h6, 3'h0, 4'h1, 1'h1, 20'h44400}
  };
  // Half period of the 200 MHz clock
  always #2.5 clk = ~clk;
  init_model u_init (.clk, .retryEnable, .initiatorId, .selectStart, .evValid, .evKind,
    .lastPhase, .lastMsgOut, .identifyValid, .identifyByte, .retryDone, .cmdValid,
    .cmdOpcode, .blockVec, .busError, .causeSense);
  scsi_target_err dut (.clk, .rstn, .retryEnable, .initiatorId, .selectStart, .evValid,
    .evKind, .lastPhase, .lastMsgOut, .identifyValid, .identifyByte, .retryDone, .cmdValid,
    .cmdOpcode, .blockVec, .busError, .causeSense, .actValid, .actCode, .abortCmd,
    .breakLink, .lunKnown, .lunId, .discAllowed, .reselectInhibit, .senseValid,
    .senseData, .inquiryPdt);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Reconnect to unit 0 and fetch the stored word; the fetch also clears it
  task automatic readSense(input logic [`SNS_W-1:0] s);
    u_init.select();
    u_init.ident(1'h1, 6'h00);
    u_init.cmd(`OP_REQSENSE, 1'h0, 8'h00);
    check("senseValid", senseValid, 1'h1);
    check("senseData", senseData, s);
  endtask
  task automatic runRow(input row_type r);
    u_init.select();
    u_init.ident(1'h1, 6'h00);
    u_init.sendEv(r.k, r.p, r.m);
    check("actCode", actCode, r.a);
    check("abortCmd", abortCmd, r.ab);
    check("breakLink", breakLink, r.k == 3'h6 && (r.m == 3'h3 || r.m == 3'h4));
    readSense(r.s);
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #20000;
    fails++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    check("resetOuts", {actValid, lunKnown, reselectInhibit, senseValid, inquiryPdt}, '0);
    rstn = 1'h1;
    for (int i = 0; i < 15; i++) begin
      runRow(rows[i]);
    end
    // Repeated identify toggles permission; a new unit is catastrophic
    u_init.select();
    u_init.ident(1'h1, 6'h00);
    check("ident", {lunKnown, discAllowed, lunId}, 8'hC0);
    u_init.ident(1'h0, 6'h00);
    check("same unit", {actValid, discAllowed}, 2'h0);
    u_init.ident(1'h1, 6'h01);
    check("new unit", actCode, scsi_err_pkg::ACT_BUSFREE);
    check("reselectInhibit", reselectInhibit, 1'h1);
    // Catastrophe with no unit known leaves stored sense alone
    u_init.select();
    u_init.ident(1'h1, 6'h00);
    u_init.sendEv(3'h4, 3'h2, 3'h0);
    u_init.select();
    u_init.sendEv(3'h0, 3'h6, 3'h0);
    check("cat noUnit", {actCode, abortCmd}, 5'h2);
    readSense(`SNS_PARITY);
    // Unsupported unit
    u_init.select();
    u_init.ident(1'h1, 6'h01);
    u_init.cmd(`OP_INQUIRY, 1'h0, 8'h00);
    check("inquiryPdt", inquiryPdt, `PDT_NOLUN);
    u_init.cmd(`OP_REQSENSE, 1'h0, 8'h00);
    check("noUnit sense", senseData, `SNS_NOLUN);
    u_init.cmd(8'h00, 1'h0, 8'h02);
    check("noUnit cmd", actCode, scsi_err_pkg::ACT_CHECK);
    // Blocking ranks, and silence on a bus error
    u_init.select();
    u_init.ident(1'h1, 6'h00);
    u_init.cmd(8'h00, 1'h0, 8'h22);
    check("busy", actCode, scsi_err_pkg::ACT_BUSY);
    u_init.cmd(8'h00, 1'h0, 8'h60);
    check("resv", actCode, scsi_err_pkg::ACT_RESV);
    u_init.cmd(8'h00, 1'h1, 8'h02);
    check("busError", actValid, 1'h0);
    u_init.cmd(8'h00, 1'h0, 8'h00);
    check("exec", actCode, scsi_err_pkg::ACT_EXEC);
    u_init.cmd(8'h00, 1'h0, 8'h03);
    check("wrong init", actCode, scsi_err_pkg::ACT_CHECK);
    readSense(20'h44400);
    // Retries: one attempt, failure keeps the original cause
    u_init.retryEnable = 1'h1;
    u_init.select();
    u_init.ident(1'h1, 6'h00);
    u_init.sendEv(3'h3, 3'h0, 3'h0);
    check("retry cmd", actCode, scsi_err_pkg::ACT_RETRY_CMD);
    u_init.sendEv(3'h6, 3'h6, 3'h6);
    check("restore rej", actCode, scsi_err_pkg::ACT_CHECK);
    readSense(`SNS_PARITY);
    u_init.select();
    u_init.ident(1'h1, 6'h00);
    u_init.sendEv(3'h1, 3'h5, 3'h0);
    check("retry mout", actCode, scsi_err_pkg::ACT_RETRY_MSG);
    u_init.done();
    u_init.sendEv(3'h5, 3'h3, 3'h0);
    check("retry stat", actCode, scsi_err_pkg::ACT_RETRY_STAT);
    u_init.done();
    u_init.sendEv(3'h2, 3'h4, 3'h0);
    check("retry min", actCode, scsi_err_pkg::ACT_RETRY_MSG);
    u_init.sendEv(3'h2, 3'h4, 3'h0);
    check("min fail", actCode, scsi_err_pkg::ACT_BUSFREE);
    // Mid-run reset drops every level and empties the sense store
    @(negedge clk);
    rstn = 1'h0;
    @(negedge clk);
    check("midReset", {actValid, lunKnown, reselectInhibit, senseValid, inquiryPdt}, '0);
    rstn = 1'h1;
    readSense(`SNS_NONE);
    print_verdict();
  end
endmodule
`default_nettype wire
